/* bzd_defs.vh */
// Constants of the buzzer clock divider: register offsets, field positions,
// reset values and division figures.
// Assumes inclusion by bare name from the design files of this block.
`ifndef BZD_DEFS_VH
`define BZD_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BZD_OFS_MODE      8'h00
`define BZD_OFS_BUZZER    8'h04
`define BZD_OFS_COUNTER   8'h08
`define BZD_OFS_CAPTURE   8'h0c
`define BZD_OFS_STATUS    8'h10
`define BZD_OFS_MASK      8'h14
`define BZD_OFS_USABLE    8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BZD_MODE_CLK_LO   0
`define BZD_MODE_CLK_HI   1
`define BZD_MODE_EDGE_LO  2
`define BZD_MODE_EDGE_HI  3
`define BZD_BZ_ENABLE     0
`define BZD_BZ_FSEL_LO    1
`define BZD_BZ_FSEL_HI    3
`define BZD_EV_OVERFLOW   0
`define BZD_EV_CAPTURE    1
`define BZD_EV_BAD_READ   2
`define BZD_US_READ_OK    0
`define BZD_US_CAPT_OK    1
`define BZD_US_BUZZ_ON    2
`define BZD_US_MAIN_RUN   3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BZD_RST_MODE      4'h0
`define BZD_RST_BUZZER    4'h0
`define BZD_RST_MASK      3'h0

// ----------------------------------------------------------------------
// Count clock codes and main oscillator divisions
// ----------------------------------------------------------------------
`define BZD_CLK_DIV4      2'h0
`define BZD_CLK_DIV64     2'h1
`define BZD_CLK_DIV128    2'h2
`define BZD_CLK_SUB       2'h3
`define BZD_PRE_MASK4     7'h03
`define BZD_PRE_MASK64    7'h3f
`define BZD_PRE_MASK128   7'h7f

// ----------------------------------------------------------------------
// Capture edge codes
// ----------------------------------------------------------------------
`define BZD_EDGE_OFF      2'h0
`define BZD_EDGE_RISE     2'h1
`define BZD_EDGE_FALL     2'h2
`define BZD_EDGE_BOTH     2'h3

`endif

/* bzd_buzzer_div.v */
// Buzzer divider: a free-running ripple of source ticks whose selected bit
// forms a 50 percent duty square wave.
// Assumes one source tick pulse per source clock period, on pclk.
`timescale 1ns/10ps
`default_nettype none

module bzd_buzzer_div #(
  parameter WIDTH = 13
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             ce,
  input  wire             tick,
  input  wire [2:0]       freq_sel,
  input  wire             enable,
  output reg              wave
);

  reg  [WIDTH-1:0] div_count;
  reg              sel_bit;

  // Bit k toggles every 2^k ticks, so bit k is a divide by 2^(k+1).
  always @* begin
    case (freq_sel)
      3'h0:    sel_bit = div_count[3];
      3'h1:    sel_bit = div_count[4];
      3'h2:    sel_bit = div_count[7];
      3'h3:    sel_bit = div_count[8];
      3'h4:    sel_bit = div_count[9];
      3'h5:    sel_bit = div_count[10];
      3'h6:    sel_bit = div_count[11];
      default: sel_bit = div_count[12];
    endcase
  end

  // The divider never stops, so changing the code mid-tone is glitch-free
  // at the tick level; a half period may be shortened once.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= {WIDTH{1'b0}};
      wave      <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        div_count <= div_count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
      wave <= enable & sel_bit;
    end
  end

endmodule // bzd_buzzer_div

`default_nettype wire

/* bzd_top.v */
// Buzzer clock divider with its 16-bit free-running counter, capture and
// counter readout buffer, reached over APB.
// Assumes oscillator and capture pins are asynchronous to pclk and far
// slower than it; CPU clock mode inputs come from logic on pclk.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "bzd_defs.vh"

module bzd_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        main_osc_clock,
  input  wire        sub_osc_clock,
  input  wire        capture_pin,
  input  wire        main_osc_running,
  input  wire        cpu_on_sub,
  input  wire        cpu_high_speed,
  output reg         buzzer_port_pin,
  output reg         irq
);

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  reg  [1:0]  count_clock_sel;
  reg  [1:0]  capture_edge_sel;
  reg         buzzer_output_enable;
  reg  [2:0]  buzzer_freq_sel;
  reg  [15:0] free_running_counter;
  reg  [15:0] capture_value;
  reg  [2:0]  event_status;
  reg  [2:0]  event_mask;
  reg  [6:0]  prescale;
  reg         sub_pending;
  reg         capture_pending;
  reg  [2:0]  main_sync;
  reg  [2:0]  sub_sync;
  reg  [2:0]  cap_sync;
  reg  [2:0]  read_clear;
  reg         read_was_bad;
  reg  [31:0] next_prdata;
  reg         next_pslverr;
  reg         source_tick;
  reg         main_count_tick;

  wire        buzzer_wave;
  wire        main_edge;
  wire        sub_edge;
  wire        cap_rise;
  wire        cap_fall;
  wire        capture_trigger;
  wire        main_half_tick;
  wire        sub_sync_tick;
  wire        sub_selected;
  wire        readout_valid;
  wire        capture_usable;
  wire        buzzer_active;
  wire        counter_wrap;
  wire        setup_phase;
  wire        access_done;
  wire [2:0]  new_events;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Edges are taken between the second and third stage, so the first stage
  // feeds nothing but the second.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_sync <= 3'h0;
      sub_sync  <= 3'h0;
      cap_sync  <= 3'h0;
    end else if (ce) begin
      main_sync <= {main_sync[1:0], main_osc_clock};
      sub_sync  <= {sub_sync[1:0], sub_osc_clock};
      cap_sync  <= {cap_sync[1:0], capture_pin};
    end
  end

  assign main_edge = main_sync[1] & ~main_sync[2];
  assign sub_edge  = sub_sync[1] & ~sub_sync[2];
  assign cap_rise  = cap_sync[1] & ~cap_sync[2];
  assign cap_fall  = ~cap_sync[1] & cap_sync[2];

  // ----------------------------------------------------------------------
  // Source clock selection
  // ----------------------------------------------------------------------
  assign sub_selected   = (count_clock_sel == `BZD_CLK_SUB);
  assign main_half_tick = main_edge & prescale[0];
  assign sub_sync_tick  = main_edge & sub_pending;

  always @* begin
    case (count_clock_sel)
      `BZD_CLK_DIV4:
        main_count_tick = main_edge &
          ((prescale & `BZD_PRE_MASK4) == `BZD_PRE_MASK4);
      `BZD_CLK_DIV64:
        main_count_tick = main_edge &
          ((prescale & `BZD_PRE_MASK64) == `BZD_PRE_MASK64);
      `BZD_CLK_DIV128:
        main_count_tick = main_edge & (prescale == `BZD_PRE_MASK128);
      default:
        main_count_tick = 1'b0;
    endcase
  end

  // With the buzzer off the subsystem clock is retimed onto main oscillator
  // edges so capture and readout see a clean count; that costs counting
  // whenever the main oscillator is stopped.
  always @* begin
    if (sub_selected) begin
      if (buzzer_output_enable) begin
        source_tick = sub_edge;
      end else begin
        source_tick = sub_sync_tick;
      end
    end else begin
      source_tick = main_count_tick;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale    <= 7'h00;
      sub_pending <= 1'b0;
    end else if (ce) begin
      if (main_edge) begin
        prescale <= prescale + 7'h01;
      end
      if (sub_edge) begin
        sub_pending <= 1'b1;
      end else if (main_edge) begin
        sub_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Counter and capture
  // ----------------------------------------------------------------------
  assign counter_wrap = source_tick & (free_running_counter == 16'hffff);
  assign capture_trigger =
    (capture_edge_sel[0] & cap_rise) | (capture_edge_sel[1] & cap_fall);

  // A trigger is held until the next main divided-by-two tick, so nothing
  // is captured while the main oscillator stands still.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_running_counter <= 16'h0000;
      capture_value        <= 16'h0000;
      capture_pending      <= 1'b0;
    end else if (ce) begin
      if (source_tick) begin
        free_running_counter <= free_running_counter + 16'h0001;
      end
      if (main_half_tick & capture_pending) begin
        capture_value <= free_running_counter;
      end
      if (capture_trigger) begin
        capture_pending <= 1'b1;
      end else if (main_half_tick) begin
        capture_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Usability of capture and readout
  // ----------------------------------------------------------------------
  assign readout_valid = sub_selected ?
    (~buzzer_output_enable & main_osc_running) :
    (~cpu_on_sub & cpu_high_speed & main_osc_running);
  assign capture_usable = main_osc_running &
    ~(sub_selected & buzzer_output_enable);
  assign buzzer_active = buzzer_output_enable &
    (sub_selected | main_osc_running);

  // ----------------------------------------------------------------------
  // Buzzer
  // ----------------------------------------------------------------------
  bzd_buzzer_div #(
    .WIDTH    (13)
  ) u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .tick     (source_tick),
    .freq_sel (buzzer_freq_sel),
    .enable   (buzzer_output_enable),
    .wave     (buzzer_wave)
  );

  // A disabled buzzer leaves the pin low, which matches a cleared latch.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buzzer_port_pin <= 1'b0;
    end else if (ce) begin
      buzzer_port_pin <= buzzer_wave & buzzer_output_enable;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;

  always @* begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      `BZD_OFS_MODE:
        next_prdata[3:0] = {capture_edge_sel, count_clock_sel};
      `BZD_OFS_BUZZER:
        next_prdata[3:0] = {buzzer_freq_sel, buzzer_output_enable};
      `BZD_OFS_COUNTER:
        next_prdata[15:0] = free_running_counter;
      `BZD_OFS_CAPTURE:
        next_prdata[15:0] = capture_value;
      `BZD_OFS_STATUS:
        next_prdata[2:0] = event_status;
      `BZD_OFS_MASK:
        next_prdata[2:0] = event_mask;
      `BZD_OFS_USABLE:
        next_prdata[3:0] = {main_osc_running, buzzer_active,
                            capture_usable, readout_valid};
      default:
        next_pslverr = 1'b1;
    endcase
  end

  // Read data is latched in the setup cycle, acting as the counter read
  // buffer; the access phase then completes with no wait state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      read_clear   <= 3'h0;
      read_was_bad <= 1'b0;
    end else if (ce) begin
      pready <= setup_phase;
      if (setup_phase) begin
        prdata       <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr      <= next_pslverr;
        read_clear   <= (~pwrite && paddr == `BZD_OFS_STATUS) ?
                        event_status : 3'h0;
        read_was_bad <= ~pwrite & (paddr == `BZD_OFS_COUNTER) &
                        ~readout_valid;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {capture_edge_sel, count_clock_sel}     <= `BZD_RST_MODE;
      {buzzer_freq_sel, buzzer_output_enable} <= `BZD_RST_BUZZER;
      event_mask           <= `BZD_RST_MASK;
    end else if (ce && access_done && pwrite) begin
      case (paddr)
        `BZD_OFS_MODE: begin
          count_clock_sel  <= pwdata[`BZD_MODE_CLK_HI:`BZD_MODE_CLK_LO];
          capture_edge_sel <= pwdata[`BZD_MODE_EDGE_HI:`BZD_MODE_EDGE_LO];
        end
        `BZD_OFS_BUZZER: begin
          buzzer_output_enable <= pwdata[`BZD_BZ_ENABLE];
          buzzer_freq_sel <= pwdata[`BZD_BZ_FSEL_HI:`BZD_BZ_FSEL_LO];
        end
        `BZD_OFS_MASK: begin
          event_mask <= pwdata[2:0];
        end
        default: begin
          event_mask <= event_mask;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  // Only bits that were actually returned by the status read are cleared,
  // and a new event in the same cycle sets its bit again.
  assign new_events = {access_done & read_was_bad,
                       main_half_tick & capture_pending,
                       counter_wrap};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_status <= 3'h0;
      irq          <= 1'b0;
    end else if (ce) begin
      if (access_done) begin
        event_status <= (event_status & ~read_clear) | new_events;
      end else begin
        event_status <= event_status | new_events;
      end
      irq <= |(event_status & event_mask);
    end
  end

endmodule // bzd_top

`default_nettype wire

/* bzd_properties.sv */
// Checker for bzd_top: APB answers, buzzer pin, interrupt and usable flags.
// Assumes it is bound to bzd_top by the statement after the module.
`timescale 1ns/10ps
`default_nettype none

module bzd_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        main_osc_running,
  input wire logic        cpu_on_sub,
  input wire logic        cpu_high_speed,
  input wire logic        buzzer_port_pin,
  input wire logic        irq
);
  logic [1:0] mode_q;
  logic       en_q;
  logic [2:0] mask_q;
  wire        wr  = psel && penable && pready && pwrite && ce;
  wire        sub = mode_q == 2'h3;
  wire        run = main_osc_running;
  wire  [3:0] use_exp = {run, en_q && (sub || run), run && !(sub && en_q),
                         run && (sub ? !en_q : !cpu_on_sub && cpu_high_speed)};

  // Shadow copies of the written control fields.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
      en_q   <= 1'b0;
      mask_q <= 3'h0;
    end else if (wr) begin
      if (paddr == 8'h00) mode_q <= pwdata[1:0];
      if (paddr == 8'h04) en_q <= pwdata[0];
      if (paddr == 8'h14) mask_q <= pwdata[2:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_read_use;
    s_setup ##0 (!pwrite && paddr == 8'h18);
  endsequence

  a_pready_setup: assert property (s_setup |=> pready)
    else $error("no pready after setup");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (s_setup ##0
    (paddr > 8'h18 || paddr[1:0] != 2'h0) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_prdata_hold: assert property (!(psel && !penable && ce) |=>
    $stable(prdata))
    else $error("prdata moved outside setup");
  a_pin_quiet_off: assert property (!en_q [*4] |->
    !buzzer_port_pin)
    else $error("buzzer pin active while disabled");
  a_irq_masked: assert property ((mask_q == 3'h0) [*2] |-> !irq)
    else $error("irq with all events masked");
  a_usable_read: assert property (
    s_read_use |=> prdata[3:0] == $past(use_exp))
    else $error("usable flags wrong");
endmodule // bzd_properties

bind bzd_top bzd_properties u_props (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .main_osc_running,
  .cpu_on_sub, .cpu_high_speed, .buzzer_port_pin, .irq);

`default_nettype wire

/* tb_top.sv */
// Testbench for bzd_top: registers, usable flags, events and buzzer periods.
// Assumes the checker file is compiled with it; oscillators come from here.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  logic        main_osc_clock = 1'b0;
  logic        sub_osc_clock = 1'b0;
  logic        capture_pin = 1'b0;
  logic        main_osc_running = 1'b1;
  logic        cpu_on_sub = 1'b0;
  logic        cpu_high_speed = 1'b1;
  wire         buzzer_port_pin;
  wire         irq;
  logic [1:0]  ph = 2'h0;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          checked = 0;

  bzd_top dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .main_osc_clock, .sub_osc_clock,
    .capture_pin, .main_osc_running, .cpu_on_sub, .cpu_high_speed,
    .buzzer_port_pin, .irq);

  // --------------------------------------------------------------------
  // Clock and oscillators
  // --------------------------------------------------------------------
  initial begin
    forever #25 pclk = ~pclk;
  end

  // Both oscillators toggle every 2 pclk, the main one only while main_osc_running is set, the fastest the pins accept.
  always @(posedge pclk) begin
    ph <= ph + 2'h1;
    if (ph[0]) sub_osc_clock <= ~sub_osc_clock;
    if (ph[0] && main_osc_running) main_osc_clock <= ~main_osc_clock;
  end

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic gap(output int c);
    logic v;
    v = buzzer_port_pin;
    c = 0;
    while (buzzer_port_pin === v && c < 20000) begin
      @(posedge pclk);
      c++;
    end
  endtask

  // The first gap only finds a true edge; the ones after it are measured.
  task automatic meas(input int e, input logic duty);
    int h;
    repeat (6) @(posedge pclk);
    gap(h);
    gap(h);
    chk(h >= e - 1 && h <= e + 1, 1'b1, "half period");
    if (duty) begin
      gap(h);
      chk(h >= e - 1 && h <= e + 1, 1'b1, "other half");
    end
  endtask

  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] a [4] = '{8'h00, 8'h04, 8'h10, 8'h14};
    chk(buzzer_port_pin, 1'b0, "pin after reset");
    chk(irq, 1'b0, "irq after reset");
    foreach (a[i]) begin
      apb(a[i], 1'b0, 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    apb(8'h40, 1'b1, 32'hffff_ffff);
    chk(err, 1'b1, "unmapped write");
    apb(8'h42, 1'b0, 32'h0);
    chk(err, 1'b1, "unmapped read");
    apb(8'h04, 1'b1, 32'h0000_000f);
    apb(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h0000_000f, "buzzer control");
    apb(8'h04, 1'b1, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_usable;
    logic [3:0] e;
    logic s;
    for (int i = 0; i < 32; i++) begin
      s = i[4];
      apb(8'h00, 1'b1, {30'h0, s, s});
      apb(8'h04, 1'b1, {31'h0, i[3]});
      main_osc_running <= i[0];
      cpu_on_sub <= i[1];
      cpu_high_speed <= i[2];
      apb(8'h18, 1'b0, 32'h0);
      e = {i[0], i[3] && (s || i[0]), i[0] && !(s && i[3]),
           i[0] && (s ? !i[3] : !i[1] && i[2])};
      chk(rd, {28'h0, e}, "usable flags");
    end
    main_osc_running <= 1'b1;
    cpu_on_sub <= 1'b0;
    cpu_high_speed <= 1'b1;
    $display("test usable done");
  endtask

  task automatic t_irq;
    logic [31:0] c0;
    apb(8'h04, 1'b1, 32'h0);
    apb(8'h00, 1'b1, 32'h4);
    apb(8'h10, 1'b0, 32'h0);
    capture_pin <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(irq, 1'b0, "masked irq");
    apb(8'h14, 1'b1, 32'h2);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1, "capture irq");
    apb(8'h10, 1'b0, 32'h0);
    chk(rd[1], 1'b1, "capture event");
    apb(8'h0c, 1'b0, 32'h0);
    chk(rd != 32'h0 && rd[31:16] == 16'h0, 1'b1, "capture value");
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0, "irq after clear");
    capture_pin <= 1'b0;
    main_osc_running <= 1'b0;
    repeat (8) @(posedge pclk);
    capture_pin <= 1'b1;
    repeat (40) @(posedge pclk);
    apb(8'h10, 1'b0, 32'h0);
    chk(rd[1], 1'b0, "capture, main stopped");
    main_osc_running <= 1'b1;
    cpu_on_sub <= 1'b1;
    apb(8'h14, 1'b1, 32'h4);
    apb(8'h08, 1'b0, 32'h0);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1, "bad read irq");
    cpu_on_sub <= 1'b0;
    apb(8'h10, 1'b0, 32'h0);
    chk(rd[2], 1'b1, "bad read event");
    // A frozen block must not count, though the oscillators keep running.
    apb(8'h08, 1'b0, 32'h0);
    c0 = rd;
    ce <= 1'b0;
    repeat (50) @(posedge pclk);
    ce <= 1'b1;
    apb(8'h08, 1'b0, 32'h0);
    chk(rd - c0 < 32'h2, 1'b1, "frozen by clock enable");
    apb(8'h14, 1'b1, 32'h0);
    apb(8'h00, 1'b1, 32'h3);
    main_osc_running <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(8'h08, 1'b0, 32'h0);
    c0 = rd;
    repeat (100) @(posedge pclk);
    apb(8'h08, 1'b0, 32'h0);
    chk(rd, c0, "count halts");
    main_osc_running <= 1'b1;
    repeat (100) @(posedge pclk);
    apb(8'h08, 1'b0, 32'h0);
    chk(rd == c0, 1'b0, "count runs");
    $display("test events done");
  endtask

  task automatic t_freq;
    int d [8] = '{16, 32, 256, 512, 1024, 2048, 4096, 8192};
    int p [3] = '{4, 64, 128};
    logic hi;
    apb(8'h00, 1'b1, 32'h0);
    apb(8'h04, 1'b1, 32'h0);
    hi = 1'b0;
    repeat (400) begin
      @(posedge pclk);
      hi = hi | buzzer_port_pin;
    end
    chk(hi, 1'b0, "pin while disabled");
    for (int k = 0; k < 3; k++) begin
      apb(8'h00, 1'b1, {30'h0, k[1:0]});
      apb(8'h04, 1'b1, 32'h1);
      meas(p[k] * 32, 1'b0);
    end
    apb(8'h00, 1'b1, 32'h3);
    cpu_on_sub <= 1'b1;
    main_osc_running <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      apb(8'h04, 1'b1, {28'h0, k[2:0], 1'b1});
      meas(2 * d[k], k == 0);
    end
    apb(8'h04, 1'b1, 32'h0);
    repeat (4) @(posedge pclk);
    chk(buzzer_port_pin, 1'b0, "pin after tone");
    $display("test buzzer done");
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_usable;
    t_irq;
    t_freq;
    final_report;
  end

  initial begin
    #(110000 * 50);
    num_errors++;
    final_report;
  end
endmodule // tb_top

`default_nettype wire
